// *** core/stepper_cmd_decoder.sv ***
// Control-mode and register-select command decoder for a multi-axis stepper sequencer.
// Assumes the host bus pins are asynchronous and the motion logic shares this clock.
//
// Summary of operation
// (RULE1) top bits 01 select the control-mode command
// (RULE2) mode bit 4 drives the aux output pin
// (RULE3) mode bit 5 picks S-curve, else linear ramp
// (RULE4) mode bit 0 stops pulses on origin low
// (RULE5) mode bit 1 decelerates on slowdown low
// (RULE6) mode bit 2 stops at preset count zero
// (RULE7) mode bit 3 sets negative run direction
// (RULE8) host selects a register before each access
// (RULE9) register select refreshes the read buffer
// (RULE10) low byte written last commits the register
// (RULE11) registers one to seven read only when extended
// (RULE12) hold bit freezes preset counter, else decrements
// (RULE13) ramp interrupt when count below ramp point
// (RULE14) host clears ramp interrupt by writing zero
// (RULE15) interrupt pin ORs ramp, stop and start
// (RULE16) parameter registers keep fixed bit widths
// (RULE17) select bit 4 ramp interrupt, bit 3 hold
// (RULE18) top bits 10 select the register-select command
// (RULE19) each axis keeps its own settings copy
`timescale 1ns/1ps
module stepper_cmd_decoder #(
  parameter int NUM_AXES = 4
) (
  // clock and reset
  input  wire logic                                 clock,
  input  wire logic                                 arst_n,
  // host bus pins
  input  wire logic                                 cs_n,
  input  wire logic                                 rd_n,
  input  wire logic                                 wr_n,
  input  wire logic [1:0]                           addr,
  input  wire logic [stepper_cmd_pkg::AXIS_BITS-1:0] axis_addr,
  input  wire logic [7:0]                           data_in,
  output logic      [7:0]                           data_out,
  output logic                                      data_oe_n,
  output logic                                      irq_n,
  // axis pins
  input  wire logic [NUM_AXES-1:0]                  origin_input_n,
  input  wire logic [NUM_AXES-1:0]                  slowdown_input_n,
  output logic      [NUM_AXES-1:0]                  aux_output_pin,
  // from the motion logic
  input  wire logic [NUM_AXES-1:0]                  output_pulse,
  input  wire logic [NUM_AXES-1:0]                  high_speed_run,
  input  wire logic [NUM_AXES-1:0]                  stop_int_src,
  input  wire logic [NUM_AXES-1:0]                  ext_start_evt,
  // to the motion logic
  output stepper_cmd_pkg::ctrl_mode_t               axis_mode [NUM_AXES],
  output logic      [NUM_AXES-1:0]                  stop_request,
  output logic      [NUM_AXES-1:0]                  decel_request
);
  localparam int MEM_AW = stepper_cmd_pkg::AXIS_BITS + stepper_cmd_pkg::REG_IDX_BITS;
  localparam int DW = stepper_cmd_pkg::DATA_W;

  // idle level of the bus pins; the synchronisers reset to zero, so the
  // active-low strobes pass through them inverted to avoid a false edge
  localparam stepper_cmd_pkg::host_bus_t BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                                      default: '0};

  typedef enum logic {REFRESH_IDLE, REFRESH_LOAD} refresh_state_t;

  stepper_cmd_pkg::host_bus_t    bus_pin;
  stepper_cmd_pkg::host_bus_t    bus_s;
  stepper_cmd_pkg::host_bus_t    bus_q;
  stepper_cmd_pkg::reg_select_t  sel [NUM_AXES];
  stepper_cmd_pkg::output_mode_t out_mode [NUM_AXES];
  logic [DW-1:0]                 preset_count [NUM_AXES];
  logic [DW-1:0]                 ramp_point [NUM_AXES];
  logic [DW-1:0]                 read_buf [NUM_AXES];
  logic [7:0]                    stage_mid [NUM_AXES];
  logic [7:0]                    stage_high [NUM_AXES];
  logic [NUM_AXES-1:0]           ramp_pend;
  logic [NUM_AXES-1:0]           ext_pend;
  logic [2*NUM_AXES-1:0]         pins_s;
  logic [2*NUM_AXES-1:0]         pins_low;
  stepper_cmd_pkg::host_bus_t    bus_flip;
  logic [NUM_AXES-1:0]           origin_s;
  logic [NUM_AXES-1:0]           slowdown_s;
  logic                          wr_strobe;
  logic                          lane_low_wr;
  logic [DW-1:0]                 commit_value;
  logic [MEM_AW-1:0]             mem_waddr;
  logic [MEM_AW-1:0]             mem_raddr;
  logic [DW-1:0]                 mem_rdata;
  refresh_state_t                refresh_state;
  logic [stepper_cmd_pkg::AXIS_BITS-1:0] refresh_axis;
  logic [2:0]                    refresh_idx;
  stepper_cmd_pkg::reg_select_t  cmd_sel;

  // ----------------------------------------------------------------
  // command decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_kind(input logic [7:0] b, input logic [1:0] k);
    return b[7:6] == k;
  endfunction : is_kind

  function automatic logic [7:0] lane_byte(input logic [DW-1:0] w, input logic [1:0] lane);
    case (lane)
      stepper_cmd_pkg::LANE_LOW:  return w[7:0];
      stepper_cmd_pkg::LANE_MID:  return w[15:8];
      stepper_cmd_pkg::LANE_HIGH: return w[23:16];
      default:                    return stepper_cmd_pkg::BYTE_ZERO;
    endcase
  endfunction : lane_byte

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign bus_pin = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, addr: addr,
                     axis: axis_addr, data: data_in};

  sync2 #(.W($bits(stepper_cmd_pkg::host_bus_t))) u_bus_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      (bus_pin ^ BUS_IDLE),
    .q      (bus_flip)
  );

  assign bus_s = bus_flip ^ BUS_IDLE;

  sync2 #(.W(2*NUM_AXES)) u_pin_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      (~{slowdown_input_n, origin_input_n}),
    .q      (pins_low)
  );

  assign pins_s     = ~pins_low;

  assign origin_s   = pins_s[NUM_AXES-1:0];
  assign slowdown_s = pins_s[2*NUM_AXES-1:NUM_AXES];

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      bus_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
    else
      bus_q <= bus_s;
  end

  // a write is taken at the rising edge of the write strobe; address and data
  // travel through the same flops so they line up with it
  assign wr_strobe = bus_s.wr_n && !bus_q.wr_n && !bus_q.cs_n
                     && (int'(bus_q.axis) < NUM_AXES);
  assign lane_low_wr = wr_strobe && bus_q.addr == stepper_cmd_pkg::LANE_LOW;
  assign cmd_sel = stepper_cmd_pkg::reg_select_t'(bus_q.data);

  // ----------------------------------------------------------------
  // per-axis command state
  // ----------------------------------------------------------------
  for (genvar a = 0; a < NUM_AXES; a++)
  begin : g_axis
    logic axis_hit;
    logic cmd_wr;
    logic commit;

    assign axis_hit = wr_strobe && int'(bus_q.axis) == a;   // see (RULE19)
    assign cmd_wr   = axis_hit && bus_q.addr == stepper_cmd_pkg::LANE_CMD;
    assign commit   = axis_hit && bus_q.addr == stepper_cmd_pkg::LANE_LOW;  // see (RULE10)

    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        axis_mode[a] <= stepper_cmd_pkg::ctrl_mode_t'(stepper_cmd_pkg::BYTE_ZERO);
      else if (cmd_wr && is_kind(bus_q.data, stepper_cmd_pkg::CMD_CTRL_MODE))  // see (RULE1)
        axis_mode[a] <= stepper_cmd_pkg::ctrl_mode_t'(bus_q.data);
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        sel[a] <= stepper_cmd_pkg::reg_select_t'(stepper_cmd_pkg::BYTE_ZERO);
      else if (cmd_wr && is_kind(bus_q.data, stepper_cmd_pkg::CMD_REG_SELECT))  // see (RULE18)
        sel[a] <= cmd_sel;  // see (RULE17)
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        out_mode[a] <= stepper_cmd_pkg::output_mode_t'(stepper_cmd_pkg::BYTE_ZERO);
      else if (cmd_wr && is_kind(bus_q.data, stepper_cmd_pkg::CMD_OUTPUT_MODE))
        out_mode[a] <= stepper_cmd_pkg::output_mode_t'(bus_q.data);
    end

    // upper bytes wait in staging until the low byte arrives
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
      begin
        stage_mid[a]  <= stepper_cmd_pkg::BYTE_ZERO;
        stage_high[a] <= stepper_cmd_pkg::BYTE_ZERO;
      end
      else if (axis_hit && bus_q.addr == stepper_cmd_pkg::LANE_MID)
        stage_mid[a] <= bus_q.data;
      else if (axis_hit && bus_q.addr == stepper_cmd_pkg::LANE_HIGH)
        stage_high[a] <= bus_q.data;
    end

    // a host load wins over a pulse in the same cycle
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        preset_count[a] <= stepper_cmd_pkg::WORD_ZERO;
      else if (commit && sel[a].reg_idx == stepper_cmd_pkg::REG_PRESET)
        preset_count[a] <= commit_value;
      else if (output_pulse[a] && !sel[a].count_hold)  // see (RULE12)
        preset_count[a] <= preset_count[a] - 24'h000001;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        ramp_point[a] <= stepper_cmd_pkg::WORD_ZERO;
      else if (commit && sel[a].reg_idx == stepper_cmd_pkg::REG_RAMP_DOWN)
        ramp_point[a] <= commit_value;
    end

    // pending flags: set by an enabled event, cleared while the enable bit is zero
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
      begin
        ramp_pend[a] <= 1'b0;
        ext_pend[a]  <= 1'b0;
      end
      else
      begin
        if (sel[a].ramp_int_en && preset_count[a] < ramp_point[a])  // see (RULE13)
          ramp_pend[a] <= 1'b1;
        else if (!sel[a].ramp_int_en)  // see (RULE14)
          ramp_pend[a] <= 1'b0;
        if (sel[a].ext_int_en && ext_start_evt[a])
          ext_pend[a] <= 1'b1;
        else if (!sel[a].ext_int_en)
          ext_pend[a] <= 1'b0;
      end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
      begin
        stop_request[a]  <= 1'b0;
        decel_request[a] <= 1'b0;
      end
      else
      begin
        stop_request[a]  <= (axis_mode[a].origin_stop && !origin_s[a])  // see (RULE4)
                         || (axis_mode[a].preset_stop                  // see (RULE6)
                             && preset_count[a] == stepper_cmd_pkg::WORD_ZERO);
        decel_request[a] <= axis_mode[a].slowdown_en && !slowdown_s[a]  // see (RULE5)
                         && high_speed_run[a];
      end
    end

    assign aux_output_pin[a] = axis_mode[a].aux;  // see (RULE2)
  end

  // ----------------------------------------------------------------
  // register commit and read-back memory
  // ----------------------------------------------------------------
  always_comb
  begin
    commit_value = stepper_cmd_pkg::WORD_ZERO;
    mem_waddr    = {bus_q.axis, stepper_cmd_pkg::REG_PRESET};
    for (int i = 0; i < NUM_AXES; i++)
    begin
      if (int'(bus_q.axis) == i)
      begin
        commit_value = {stage_high[i], stage_mid[i], bus_q.data}
                       & stepper_cmd_pkg::width_mask(sel[i].reg_idx);  // see (RULE16)
        mem_waddr    = {bus_q.axis, sel[i].reg_idx};
      end
    end
  end

  assign mem_raddr = {bus_q.axis, cmd_sel.reg_idx};

  param_mem #(.WIDTH(DW), .AW(MEM_AW)) u_mem (
    .clock  (clock),
    .arst_n (arst_n),
    .we     (lane_low_wr),
    .waddr  (mem_waddr),
    .wdata  (commit_value),
    .raddr  (mem_raddr),
    .rdata  (mem_rdata)
  );

  // ----------------------------------------------------------------
  // read buffer refresh on register select
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      refresh_state <= REFRESH_IDLE;
      refresh_axis  <= '0;
      refresh_idx   <= stepper_cmd_pkg::REG_PRESET;
    end
    else
    begin
      case (refresh_state)
        REFRESH_IDLE:
          if (wr_strobe && bus_q.addr == stepper_cmd_pkg::LANE_CMD
              && is_kind(bus_q.data, stepper_cmd_pkg::CMD_REG_SELECT))  // see (RULE9)
          begin
            refresh_state <= REFRESH_LOAD;
            refresh_axis  <= bus_q.axis;
            refresh_idx   <= cmd_sel.reg_idx;
          end
        REFRESH_LOAD:
          refresh_state <= REFRESH_IDLE;
        default:
          refresh_state <= REFRESH_IDLE;
      endcase
    end
  end

  // the preset counter is sampled once here; later reads see a frozen copy
  for (genvar a = 0; a < NUM_AXES; a++)
  begin : g_rbuf
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        read_buf[a] <= stepper_cmd_pkg::WORD_ZERO;
      else if (refresh_state == REFRESH_LOAD && int'(refresh_axis) == a)
      begin
        if (refresh_idx == stepper_cmd_pkg::REG_PRESET)
          read_buf[a] <= preset_count[a];
        else if (out_mode[a].monitor_ext)  // see (RULE11)
          read_buf[a] <= mem_rdata;
        else
          read_buf[a] <= stepper_cmd_pkg::WORD_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // host read data and interrupt pin
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      data_out <= stepper_cmd_pkg::BYTE_ZERO;
    else
    begin
      data_out <= stepper_cmd_pkg::BYTE_ZERO;
      for (int i = 0; i < NUM_AXES; i++)
      begin
        if (int'(bus_s.axis) == i)
        begin
          if (bus_s.addr == stepper_cmd_pkg::LANE_CMD)
          begin
            data_out[stepper_cmd_pkg::STAT_STOP_INT] <= stop_int_src[i];
            data_out[stepper_cmd_pkg::STAT_RAMP_INT] <= ramp_pend[i];
            data_out[stepper_cmd_pkg::STAT_EXT_INT]  <= ext_pend[i];
          end
          else
            data_out <= lane_byte(read_buf[i], bus_s.addr);
        end
      end
    end
  end

  assign data_oe_n = bus_s.cs_n || bus_s.rd_n;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      irq_n <= 1'b1;
    else
      irq_n <= !(|ramp_pend || |stop_int_src || |ext_pend);  // see (RULE15)
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic ctrl_wr0;
  assign ctrl_wr0 = g_axis[0].cmd_wr && is_kind(bus_q.data, stepper_cmd_pkg::CMD_CTRL_MODE);

  property p_ctrl_decode;
    ctrl_wr0 |=> axis_mode[0] == stepper_cmd_pkg::ctrl_mode_t'($past(bus_q.data));
  endproperty
  a_ctrl_decode: assert property (p_ctrl_decode) else $error("control mode not taken"); // see (RULE1)

  property p_aux;
    ctrl_wr0 ##1 1'b1 |-> aux_output_pin[0] == $past(bus_q.data[4]);
  endproperty
  a_aux: assert property (p_aux) else $error("aux pin does not follow mode"); // see (RULE2)

  property p_dir_curve;
    ctrl_wr0 |=> axis_mode[0].s_curve == $past(bus_q.data[5])
                 && axis_mode[0].dir_negative == $past(bus_q.data[3]);
  endproperty
  a_dir_curve: assert property (p_dir_curve) else $error("shape or direction wrong"); // see (RULE3) (RULE7)

  property p_origin_stop;
    axis_mode[0].origin_stop && !origin_s[0] |=> stop_request[0];
  endproperty
  a_origin_stop: assert property (p_origin_stop) else $error("origin stop missed"); // see (RULE4)

  property p_decel;
    decel_request[0] |-> $past(axis_mode[0].slowdown_en) && !$past(slowdown_s[0]);
  endproperty
  a_decel: assert property (p_decel) else $error("decel without cause"); // see (RULE5)

  property p_preset_stop;
    axis_mode[0].preset_stop && preset_count[0] == stepper_cmd_pkg::WORD_ZERO |=> stop_request[0];
  endproperty
  a_preset_stop: assert property (p_preset_stop) else $error("preset zero stop missed"); // see (RULE6)

  property p_hold;
    sel[0].count_hold && !g_axis[0].commit |=> $stable(preset_count[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("held counter moved"); // see (RULE12)

  property p_ramp_irq;
    sel[0].ramp_int_en && preset_count[0] < ramp_point[0] |-> ##2 !irq_n;
  endproperty
  a_ramp_irq: assert property (p_ramp_irq) else $error("ramp interrupt missing"); // see (RULE13)

  property p_stop_irq;
    stop_int_src[0] |=> !irq_n;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop interrupt missing"); // see (RULE15)

  property p_monitor;
    refresh_state == REFRESH_LOAD && refresh_axis == '0 && refresh_idx != stepper_cmd_pkg::REG_PRESET
      && !out_mode[0].monitor_ext |=> read_buf[0] == stepper_cmd_pkg::WORD_ZERO;
  endproperty
  a_monitor: assert property (p_monitor) else $error("write-only register leaked"); // see (RULE11)

endmodule : stepper_cmd_decoder

// *** core/stepper_cmd_pkg.sv ***
// Constants, command byte views and bus carrier for the stepper command decoder.
// Assumes an 8-bit host bus with a 2-bit byte lane address and up to four axes.
package stepper_cmd_pkg;

  // ----------------------------------------------------------------
  // axis addressing and data widths
  // ----------------------------------------------------------------
  localparam int AXIS_BITS = 2;
  localparam int REG_IDX_BITS = 3;
  localparam int DATA_W = 24;

  // ----------------------------------------------------------------
  // command kinds (two top bits of a command byte)
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_CTRL_MODE   = 2'h1;
  localparam logic [1:0] CMD_REG_SELECT  = 2'h2;
  localparam logic [1:0] CMD_OUTPUT_MODE = 2'h3;

  // ----------------------------------------------------------------
  // byte lanes on the address pins
  // ----------------------------------------------------------------
  localparam logic [1:0] LANE_CMD  = 2'h0;
  localparam logic [1:0] LANE_LOW  = 2'h1;
  localparam logic [1:0] LANE_MID  = 2'h2;
  localparam logic [1:0] LANE_HIGH = 2'h3;

  // ----------------------------------------------------------------
  // parameter register indices and widths
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_PRESET     = 3'h0;
  localparam logic [2:0] REG_LOW_SPEED  = 3'h1;
  localparam logic [2:0] REG_HIGH_SPEED = 3'h2;
  localparam logic [2:0] REG_RATE       = 3'h3;
  localparam logic [2:0] REG_MULTIPLIER = 3'h4;
  localparam logic [2:0] REG_RAMP_DOWN  = 3'h5;
  localparam logic [2:0] REG_IDLE       = 3'h6;
  localparam logic [2:0] REG_PRIORITY   = 3'h7;
  localparam int W_PRESET    = 24;
  localparam int W_SPEED     = 13;
  localparam int W_RATE      = 10;
  localparam int W_RAMP_DOWN = 16;
  localparam int W_IDLE      = 3;
  localparam int W_PRIORITY  = 1;

  // ----------------------------------------------------------------
  // status word bit positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_STOP_INT = 0;
  localparam int STAT_RAMP_INT = 1;
  localparam int STAT_EXT_INT  = 2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [23:0] WORD_ZERO = 24'h000000;

  // ----------------------------------------------------------------
  // command byte views
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] kind;
    logic       s_curve;
    logic       aux;
    logic       dir_negative;
    logic       preset_stop;
    logic       slowdown_en;
    logic       origin_stop;
  } ctrl_mode_t;

  typedef struct packed {
    logic [1:0] kind;
    logic       ext_int_en;
    logic       ramp_int_en;
    logic       count_hold;
    logic [2:0] reg_idx;
  } reg_select_t;

  typedef struct packed {
    logic [1:0] kind;
    logic       monitor_ext;
    logic [4:0] other;
  } output_mode_t;

  typedef struct packed {
    logic                 cs_n;
    logic                 rd_n;
    logic                 wr_n;
    logic [1:0]           addr;
    logic [AXIS_BITS-1:0] axis;
    logic [7:0]           data;
  } host_bus_t;

  // ----------------------------------------------------------------
  // width mask of a parameter register
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] width_mask(input logic [2:0] idx);
    int w;
    logic [DATA_W:0] m;
    case (idx)
      REG_PRESET:                  w = W_PRESET;
      REG_LOW_SPEED, REG_HIGH_SPEED: w = W_SPEED;
      REG_RATE, REG_MULTIPLIER:    w = W_RATE;
      REG_RAMP_DOWN:               w = W_RAMP_DOWN;
      REG_IDLE:                    w = W_IDLE;
      default:                     w = W_PRIORITY;
    endcase
    m = (25'h0000001 << w) - 25'h0000001;
    return m[DATA_W-1:0];
  endfunction : width_mask

endpackage : stepper_cmd_pkg

// *** core/sync2.sv ***
// Two-stage level synchroniser for a bundle of pins.
// Assumes each bit is an independent slow level or is held stable around its strobe.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // pins and synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync2

// *** core/param_mem.sv ***
// Single write port, single registered read port memory for register read-back.
// Assumes the caller masks data to the register width before writing.
`timescale 1ns/1ps
module param_mem #(
  parameter int WIDTH = 24,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port, data one cycle after the address
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [2**AW];

  always_ff @(posedge clock)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= '0;
    else
      rdata <= mem[raddr];
  end
endmodule : param_mem

// *** dv/host_cpu_model.sv ***
// Host CPU model that writes command bytes over the 8-bit host bus.
// Assumes the caller runs one write at a time, from the bench's own process.
`timescale 1ns/1ps
module host_cpu_model (
  // clock
  input  wire logic                  clock,
  // host bus pins
  input  wire logic [7:0]            rd_data,
  output stepper_cmd_pkg::host_bus_t bus
);
  initial
  begin
    bus = '{1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 8'h00};
  end

  // strobe held 4 clocks each way, one above the minimum, data kept past the rise
  task automatic write_byte(input logic [1:0] lane, input logic [1:0] ax, input logic [7:0] b);
    @(negedge clock);
    bus.cs_n = 1'b0;
    bus.addr = lane;
    bus.axis = ax;
    bus.data = b;
    @(negedge clock);
    bus.wr_n = 1'b0;
    repeat (4) @(negedge clock);
    bus.wr_n = 1'b1;
    repeat (4) @(negedge clock);
    bus.cs_n = 1'b1;
    // released bus shows the inverse, not a stale value
    bus.data = ~b;
  endtask : write_byte

  // read data settles three edges after the address pins change; five are waited
  task automatic read_byte(input logic [1:0] lane, input logic [1:0] ax, output logic [7:0] b);
    @(negedge clock);
    bus.cs_n = 1'b0;
    bus.addr = lane;
    bus.axis = ax;
    @(negedge clock);
    bus.rd_n = 1'b0;
    repeat (5) @(negedge clock);
    b = rd_data;
    bus.rd_n = 1'b1;
    @(negedge clock);
    bus.cs_n = 1'b1;
  endtask : read_byte
endmodule : host_cpu_model

// *** dv/stepper_mode_and_register_select_tb_top.sv ***
// Bench for the stepper command decoder: control-mode writes and stop requests.
// Assumes the host model drives the bus and the motion-logic inputs stay idle except high_speed_run on axis 0.
`timescale 1ns/1ps
module stepper_mode_and_register_select_tb_top;
  logic                        clock = 1'b0;
  logic                        arst_n = 1'b0;
  stepper_cmd_pkg::host_bus_t  bus;
  logic [3:0]                  org_n = 4'hF, sd_n = 4'hF, hs = 4'h0, aux, stop, decel;
  logic                        irq_n;
  logic [7:0]                  rd_data, rb;
  stepper_cmd_pkg::ctrl_mode_t mode [4];
  stepper_cmd_pkg::ctrl_mode_t exp_m [4];
  stepper_cmd_pkg::ctrl_mode_t q [$][4];
  logic [31:0]                 lf = 32'h5D533151;
  int                          failures = 0, tests_run = 0;

  always #50 clock = ~clock;
  host_cpu_model u_host_cpu_model (.clock(clock), .rd_data(rd_data), .bus(bus));
  stepper_cmd_decoder #(.NUM_AXES(4)) u_stepper_cmd_decoder (.clock(clock), .arst_n(arst_n),
    .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .addr(bus.addr), .axis_addr(bus.axis),
    .data_in(bus.data), .data_out(rd_data), .data_oe_n(), .irq_n(irq_n), .origin_input_n(org_n),
    .slowdown_input_n(sd_n), .aux_output_pin(aux), .output_pulse(4'h0), .high_speed_run(hs),
    .stop_int_src(4'h0), .ext_start_evt(4'h0), .axis_mode(mode), .stop_request(stop),
    .decel_request(decel));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want)
    begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // monitor: a control-mode write lands three edges after the strobe
  // ----------------------------------------------------------------
  always @(posedge bus.wr_n)
    if (bus.addr == 2'h0 && bus.data[7:6] == 2'h1 && q.size() > 0)
    begin
      repeat (5) @(negedge clock);
      for (int i = 0; i < 4; i++)
      begin
        check(mode[i], q[0][i]);
        check({7'h00, aux[i]}, {7'h00, q[0][i][4]});
      end
      void'(q.pop_front());
    end

  initial
  begin
    repeat (3000) @(posedge clock);
    failures++;
    end_of_test();
  end

  initial
  begin
    for (int i = 0; i < 4; i++)
      exp_m[i] = 8'h00;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    // random low bits: twelve random mode-bit patterns on random axes reach the outputs
    for (int n = 0; n < 12; n++)
    begin
      lf = lfsr(lf);
      exp_m[lf[9:8]] = {2'h1, lf[5:0]};
      q.push_back(exp_m);
      u_host_cpu_model.write_byte(2'h0, lf[9:8], {2'h1, lf[5:0]});
    end
    $display("mode decode done");
    exp_m[0] = 8'h43;
    q.push_back(exp_m);
    u_host_cpu_model.write_byte(2'h0, 2'h0, 8'h43);
    org_n[0] = 1'b0;
    sd_n[0] = 1'b0;
    hs[0] = 1'b1;
    repeat (6) @(negedge clock);
    check({7'h00, stop[0]}, 8'h01);
    check({7'h00, decel[0]}, 8'h01);
    check({7'h00, irq_n}, 8'h01);
    exp_m[0] = 8'h40;
    q.push_back(exp_m);
    u_host_cpu_model.write_byte(2'h0, 2'h0, 8'h40);
    repeat (6) @(negedge clock);
    check({7'h00, stop[0]}, 8'h00);
    check({7'h00, decel[0]}, 8'h00);
    $display("stop sources done");
    // preset load high lane first; low lane commits; fresh select refreshes buffer
    u_host_cpu_model.write_byte(2'h0, 2'h0, 8'h88);
    u_host_cpu_model.write_byte(2'h3, 2'h0, 8'hC3);
    u_host_cpu_model.write_byte(2'h2, 2'h0, 8'hA5);
    u_host_cpu_model.write_byte(2'h1, 2'h0, 8'h96);
    u_host_cpu_model.write_byte(2'h0, 2'h0, 8'h88);
    u_host_cpu_model.read_byte(2'h1, 2'h0, rb);
    check(rb, 8'h96);
    u_host_cpu_model.read_byte(2'h2, 2'h0, rb);
    check(rb, 8'hA5);
    u_host_cpu_model.read_byte(2'h3, 2'h0, rb);
    check(rb, 8'hC3);
    check({7'h00, irq_n}, 8'h01);
    $display("preset read-back done");
    end_of_test();
  end
endmodule : stepper_mode_and_register_select_tb_top
